// *** verilog/spcs_regs.sv ***
// control and status word logic of the serial poller
// Summary of operation
// - run digit 1 starts host and component communication.
// - a latched fatal error blocks component communication.
// - run digit 0 means no component communication.
// - timeout digit 0..9 gives (value+1) x 500 ms response limit.
// - bits 8..15 hold component count; zero means no polling.
// - errors put code 01, 02 or 15 in status low byte.
// - watchdog: code 01 fatal, halt all, fault lamp on.
// - syntax: code 02, store word address, halt polling, lamp.
// - bad memory address: fatal code 15, stop polling, lamp.
// - any error stops polling and clears the status run digit to 0.
// - fatal error sets top status digit to 8.
// - syntax address word keeps the first error's address.
// - no error: low byte holds last completed unit, else 00.
// - no error: run digit 1 while running, 0 while stopped.
`timescale 1ns/1ps
module spcs_regs import spcs_pkg::*; #(
  parameter int STEP_CYC = SPCS_TMO_STEP_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // shared word access from host
  input wire spcs_req_t req_i,
  output logic [15:0] rdata_o,
  // polling engine
  input wire spcs_evt_t evt_i,
  input wire logic cycle_end_i,
  input wire logic access_i,
  output logic poll_en_o,
  output logic host_en_o,
  output logic [3:0] tmo_digit_o,
  output logic [7:0] unit_cnt_o,
  output logic timeout_o,
  // indicator
  output logic fault_lamp_o
);
  logic [15:0] ctrl_ff;
  logic [15:0] stat_ff;
  logic [15:0] synx_ff;
  logic synx_held_ff;
  logic fatal_ff;
  logic err_ff;
  logic [3:0] run_ff;
  logic [3:0] tmo_ff;
  logic [7:0] cnt_ff;
  spcs_state_t state_ff;
  spcs_state_t nxt_state;
  logic expired;

  wire wr_ctrl = req_i.wr && (req_i.idx == SPCS_IDX_CTRL);
  wire [3:0] run_dig = ctrl_ff[SPCS_RUN_LSB +: 4];
  wire fatal_evt = evt_i.wdt || evt_i.alloc || expired;
  wire any_evt = fatal_evt || evt_i.syntax;
  // sampled copy only refreshed between cycles, never mid-access
  wire resample = cycle_end_i || (state_ff != SPCS_ST_RUN);
  wire go = (run_ff == SPCS_DIG_RUN) && (cnt_ff != 8'h00)
    && !fatal_ff && !err_ff;
  wire [7:0] code = (evt_i.wdt || expired) ? SPCS_ERR_WDT :
    evt_i.alloc ? SPCS_ERR_ALLOC : SPCS_ERR_SYNTAX;
  wire [3:0] live_run = (state_ff == SPCS_ST_RUN) ? SPCS_DIG_RUN :
    SPCS_DIG_ZERO;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SPCS_ST_STOP: begin
        if (go && !any_evt) nxt_state = SPCS_ST_RUN;
      end
      SPCS_ST_RUN: begin
        if (any_evt) nxt_state = SPCS_ST_HALT;
        else if (!go) nxt_state = SPCS_ST_STOP;
      end
      SPCS_ST_HALT: begin
        nxt_state = SPCS_ST_HALT;
      end
      default: nxt_state = SPCS_ST_STOP;
    endcase
  end

  spcs_timer #(
    .STEP_CYC(STEP_CYC)
  ) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(access_i && (state_ff == SPCS_ST_RUN)),
    .stop_i(evt_i.done || (state_ff != SPCS_ST_RUN)),
    .limit_i(tmo_ff),
    .expired_o(expired)
  );

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_ff <= SPCS_CTRL_RST;
      run_ff <= 4'h0;
      tmo_ff <= 4'h0;
      cnt_ff <= 8'h00;
    end else begin
      if (wr_ctrl) ctrl_ff <= req_i.wdata;
      if (resample) begin
        run_ff <= run_dig;
        tmo_ff <= ctrl_ff[SPCS_TMO_LSB +: 4];
        cnt_ff <= ctrl_ff[SPCS_CNT_LSB +: 8];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= SPCS_ST_STOP;
      stat_ff <= SPCS_STAT_RST;
      synx_ff <= 16'h0000;
      synx_held_ff <= 1'b0;
      fatal_ff <= 1'b0;
      err_ff <= 1'b0;
      fault_lamp_o <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (fatal_ff) begin
        stat_ff <= stat_ff;
      end else if (any_evt) begin
        err_ff <= 1'b1;
        fault_lamp_o <= 1'b1;
        fatal_ff <= fatal_evt;
        stat_ff <= {fatal_evt ? SPCS_DIG_FATAL : SPCS_DIG_ZERO,
          SPCS_DIG_ZERO, code};
      end else if (!err_ff) begin
        stat_ff[15:8] <= {SPCS_DIG_ZERO, live_run};
        if (evt_i.done && state_ff == SPCS_ST_RUN)
          stat_ff[7:0] <= bcd8(evt_i.unit);
        else if (!go) stat_ff[7:0] <= 8'h00;
      end
      if (evt_i.syntax && !synx_held_ff && !fatal_ff) begin
        synx_ff <= evt_i.addr;
        synx_held_ff <= 1'b1;
      end
    end
  end

  // output registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 16'h0000;
      poll_en_o <= 1'b0;
      host_en_o <= 1'b0;
      tmo_digit_o <= 4'h0;
      unit_cnt_o <= 8'h00;
      timeout_o <= 1'b0;
    end else begin
      if (req_i.rd) begin
        case (req_i.idx)
          SPCS_IDX_CTRL: rdata_o <= ctrl_ff;
          SPCS_IDX_STAT: rdata_o <= stat_ff;
          SPCS_IDX_SYNX: rdata_o <= synx_ff;
          default: rdata_o <= 16'h0000;
        endcase
      end
      poll_en_o <= (nxt_state == SPCS_ST_RUN);
      // watchdog or response timeout (code 01) stops host traffic too; others keep it
      host_en_o <= (run_ff == SPCS_DIG_RUN) &&
        !(fatal_ff && stat_ff[7:0] == SPCS_ERR_WDT);
      tmo_digit_o <= tmo_ff;
      unit_cnt_o <= cnt_ff;
      timeout_o <= expired;
    end
  end

  function automatic logic [7:0] bcd8(input logic [4:0] v);
    logic [4:0] t;
    t = (v >= 5'd30) ? 5'd3 : (v >= 5'd20) ? 5'd2 : (v >= 5'd10) ? 5'd1 :
      5'd0;
    bcd8 = {t[3:0], 4'(v - 5'(t * 5'd10))};
  endfunction : bcd8

  AST_FATAL_STOPS: assert property (@(posedge clk_i) disable iff (rst_i)
    fatal_ff |-> !poll_en_o)
    else $error("polling enabled after fatal error");
  AST_RUN_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    (run_ff != SPCS_DIG_RUN) |=> !poll_en_o)
    else $error("polling while run digit not 1");
  AST_CNT_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    (cnt_ff == 8'h00) |=> !poll_en_o)
    else $error("polling with zero components");
  AST_WDT_CODE: assert property (@(posedge clk_i) disable iff (rst_i)
    (evt_i.wdt && !fatal_ff) |=> (stat_ff == 16'h8001) && fault_lamp_o)
    else $error("watchdog status wrong");
  AST_ALLOC_CODE: assert property (@(posedge clk_i) disable iff (rst_i)
    (evt_i.alloc && !evt_i.wdt && !expired && !fatal_ff)
    |=> stat_ff == 16'h8015)
    else $error("allocation status wrong");
  AST_SYNTAX_CODE: assert property (@(posedge clk_i) disable iff (rst_i)
    (evt_i.syntax && !fatal_evt && !fatal_ff)
    |=> stat_ff == 16'h0002 && fault_lamp_o)
    else $error("syntax status wrong");
  AST_ERR_STOPS: assert property (@(posedge clk_i) disable iff (rst_i)
    (any_evt && state_ff == SPCS_ST_RUN) |=> ##1 !poll_en_o)
    else $error("error did not stop polling");
  AST_FATAL_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    fatal_ff |=> $stable(stat_ff) && stat_ff[15])
    else $error("fatal status changed");
  AST_SYNX_FIRST: assert property (@(posedge clk_i) disable iff (rst_i)
    synx_held_ff |=> $stable(synx_ff))
    else $error("syntax address overwritten");
  AST_RUN_DIGIT: assert property (@(posedge clk_i) disable iff (rst_i)
    (!err_ff && !any_evt && state_ff == SPCS_ST_RUN)
    |=> stat_ff[11:8] == SPCS_DIG_RUN)
    else $error("run digit not shown");
  AST_LOW_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
    (!err_ff && !any_evt && !go && state_ff != SPCS_ST_RUN)
    |=> stat_ff[7:0] == 8'h00)
    else $error("unit number not cleared while stopped");
  AST_CTRL_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == SPCS_ST_RUN && !cycle_end_i)
    |=> $stable(run_ff) && $stable(tmo_ff) && $stable(cnt_ff))
    else $error("control sample changed mid cycle");
  COV_RUN: cover property (@(posedge clk_i) disable iff (rst_i)
    !poll_en_o ##1 poll_en_o);
  COV_WDT: cover property (@(posedge clk_i) disable iff (rst_i)
    poll_en_o ##1 evt_i.wdt);
  COV_SYNTAX: cover property (@(posedge clk_i) disable iff (rst_i)
    poll_en_o ##1 evt_i.syntax);
  COV_DONE: cover property (@(posedge clk_i) disable iff (rst_i)
    poll_en_o && evt_i.done);
  COV_ALLOC: cover property (@(posedge clk_i) disable iff (rst_i)
    poll_en_o ##1 evt_i.alloc);
endmodule : spcs_regs

// *** verilog/spcs_pkg.sv ***
// package: constants and types for the poller control/status block
package spcs_pkg;
  // register index (word offsets as printed)
  localparam logic [1:0] SPCS_IDX_CTRL = 2'h0;
  localparam logic [1:0] SPCS_IDX_STAT = 2'h1;
  localparam logic [1:0] SPCS_IDX_SYNX = 2'h2;
  // control word field positions
  localparam int SPCS_RUN_LSB = 0;
  localparam int SPCS_TMO_LSB = 4;
  localparam int SPCS_CNT_LSB = 8;
  // digit values
  localparam logic [3:0] SPCS_DIG_RUN = 4'h1;
  localparam logic [3:0] SPCS_DIG_FATAL = 4'h8;
  localparam logic [3:0] SPCS_DIG_ZERO = 4'h0;
  // error codes (bcd)
  localparam logic [7:0] SPCS_ERR_WDT = 8'h01;
  localparam logic [7:0] SPCS_ERR_SYNTAX = 8'h02;
  localparam logic [7:0] SPCS_ERR_ALLOC = 8'h15;
  // reset values
  localparam logic [15:0] SPCS_CTRL_RST = 16'h0000;
  localparam logic [15:0] SPCS_STAT_RST = 16'h0000;
  // timing
  localparam int SPCS_CLK_HZ = 10000000;
  localparam int SPCS_TMO_STEP_MS = 500;
  localparam int SPCS_TMO_STEP_CYC = SPCS_CLK_HZ / 1000 * SPCS_TMO_STEP_MS;
  localparam int SPCS_MAX_UNITS = 32;
  // register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] idx;
    logic [15:0] wdata;
  } spcs_req_t;
  // event inputs from the polling engine
  typedef struct packed {
    logic wdt;
    logic syntax;
    logic alloc;
    logic done;
    logic [4:0] unit;
    logic [15:0] addr;
  } spcs_evt_t;
  typedef enum logic [2:0] {
    SPCS_ST_STOP = 3'b001,
    SPCS_ST_RUN = 3'b010,
    SPCS_ST_HALT = 3'b100
  } spcs_state_t;
endpackage : spcs_pkg

// *** verilog/spcs_timer.sv ***
// response monitor: counts 500 ms steps up to (digit+1)
`timescale 1ns/1ps
module spcs_timer import spcs_pkg::*; #(
  parameter int STEP_CYC = SPCS_TMO_STEP_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic start_i,
  input wire logic stop_i,
  input wire logic [3:0] limit_i,
  // result
  output logic expired_o
);
  logic [31:0] cyc_ff;
  logic [3:0] step_ff;
  logic busy_ff;
  wire tick = busy_ff && (cyc_ff == 32'(STEP_CYC - 1));
  wire last = tick && (step_ff == limit_i);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cyc_ff <= 32'h0;
      step_ff <= 4'h0;
      busy_ff <= 1'b0;
      expired_o <= 1'b0;
    end else begin
      expired_o <= last;
      if (start_i || stop_i || last) begin
        cyc_ff <= 32'h0;
        step_ff <= 4'h0;
        busy_ff <= start_i;
      end else if (tick) begin
        cyc_ff <= 32'h0;
        step_ff <= step_ff + 4'h1;
      end else if (busy_ff) begin
        cyc_ff <= cyc_ff + 32'h1;
      end
    end
  end
endmodule : spcs_timer

// *** testbench/spcs_host_model.sv ***
// host controller model: word requests to the control block
`timescale 1ns/1ps
module spcs_host_model import spcs_pkg::*; (
  // clock
  input wire logic clk_i,
  // request and answer
  output spcs_req_t req_o,
  input wire logic [15:0] rdata_i
);
  initial req_o = '0;
  // released index and data lines show the inverse, not a stale value
  task automatic put(input logic w, input logic [1:0] i,
                     input logic [15:0] d);
    @(negedge clk_i);
    req_o <= {w, ~w, i, d};
    @(negedge clk_i);
    req_o <= {2'b00, ~i, ~d};
  endtask : put
  // read answer is taken two full cycles after the request is driven
  task automatic get(input logic [1:0] i, output logic [15:0] d);
    put(1'b0, i, 16'h0000);
    @(negedge clk_i);
    d = rdata_i;
  endtask : get
endmodule : spcs_host_model

// *** testbench/spcs_regs_test.sv ***
// self-checking bench for the control and status word logic
`timescale 1ns/1ps
module spcs_regs_test;
  import spcs_pkg::*;
  // short step keeps the response timer run brief
  localparam int STEP = 10;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  spcs_req_t req;
  spcs_evt_t evt = '0;
  spcs_evt_t e;
  logic [15:0] rdata;
  logic [15:0] rd_v;
  logic cycle_end = 1'b0;
  logic access = 1'b0;
  logic poll_en, host_en, timeout, lamp;
  logic [3:0] tmo_digit;
  logic [7:0] unit_cnt;
  logic [15:0] exps [3] = '{16'h8001, 16'h8015, 16'h0002};
  int fail_count = 0;
  int checked = 0;
  int n;
  always #50 clk_i = ~clk_i;
  spcs_regs #(.STEP_CYC(STEP)) spcs_regs_inst (.clk_i(clk_i),
    .rst_i(rst_i), .req_i(req), .rdata_o(rdata), .evt_i(evt),
    .cycle_end_i(cycle_end), .access_i(access), .poll_en_o(poll_en),
    .host_en_o(host_en), .tmo_digit_o(tmo_digit), .unit_cnt_o(unit_cnt),
    .timeout_o(timeout), .fault_lamp_o(lamp));
  spcs_host_model host (.clk_i(clk_i), .req_o(req), .rdata_i(rdata));
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    if (fail_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  task automatic idle(input int c);
    repeat (c) @(negedge clk_i);
  endtask : idle
  task automatic pulse_evt(input spcs_evt_t v);
    @(negedge clk_i);
    evt = v;
    @(negedge clk_i);
    evt = '0;
  endtask : pulse_evt
  // control write then room for sample and state steps
  task automatic ctrl(input logic [15:0] w);
    host.put(1'b1, SPCS_IDX_CTRL, w);
    idle(3);
  endtask : ctrl
  initial begin
    idle(2);
    rst_i = 1'b0;
    host.get(SPCS_IDX_CTRL, rd_v);
    chk("ctrl_rst", rd_v, SPCS_CTRL_RST);
    host.get(SPCS_IDX_STAT, rd_v);
    chk("stat_rst", rd_v, SPCS_STAT_RST);
    chk("lamp_rst", {15'h0, lamp}, 16'h0000);
    ctrl(16'h0001);
    chk("poll_cnt0", {15'h0, poll_en}, 16'h0000);
    ctrl(16'h0300);
    chk("poll_stop", {15'h0, poll_en}, 16'h0000);
    ctrl(16'h0351);
    chk("run_en", {14'h0, poll_en, host_en}, 16'h0003);
    chk("fields", {4'h0, tmo_digit, unit_cnt}, 16'h0503);
    host.put(1'b1, SPCS_IDX_STAT, 16'hFFFF);
    host.get(SPCS_IDX_STAT, rd_v);
    chk("stat_run", rd_v, 16'h0100);
    pulse_evt('{done: 1'b1, unit: 5'd17, default: '0});
    host.get(SPCS_IDX_STAT, rd_v);
    chk("stat_done", rd_v, 16'h0117);
    host.get(2'h3, rd_v);
    chk("idx3", rd_v, 16'h0000);
    ctrl(16'h0211);
    chk("cnt_hold", {8'h0, unit_cnt}, 16'h0003);
    @(negedge clk_i);
    cycle_end = 1'b1;
    @(negedge clk_i);
    cycle_end = 1'b0;
    idle(2);
    chk("cnt_new", {4'h0, tmo_digit, unit_cnt}, 16'h0102);
    @(negedge clk_i);
    access = 1'b1;
    @(negedge clk_i);
    access = 1'b0;
    n = 1;
    while (timeout !== 1'b1 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    chk("tmo_span", 16'(n >= 2 * STEP && n <= 2 * STEP + 3), 16'h0001);
    idle(2);
    host.get(SPCS_IDX_STAT, rd_v);
    chk("stat_tmo", rd_v, 16'h8001);
    chk("tmo_out", {13'h0, lamp, poll_en, host_en}, 16'h0004);
    ctrl(16'h0301);
    host.get(SPCS_IDX_STAT, rd_v);
    chk("stat_kept", rd_v, 16'h8001);
    chk("poll_fatal", {15'h0, poll_en}, 16'h0000);
    // every error kind from a fresh reset
    for (int k = 0; k < 3; k++) begin
      @(negedge clk_i);
      rst_i = 1'b1;
      idle(2);
      rst_i = 1'b0;
      ctrl(16'h0101);
      e = '{wdt: k == 0, alloc: k == 1, syntax: k == 2,
            addr: 16'h1234, default: '0};
      pulse_evt(e);
      idle(1);
      host.get(SPCS_IDX_STAT, rd_v);
      chk("err_code", rd_v, exps[k]);
      chk("err_lamp", {14'h0, lamp, poll_en}, 16'h0002);
      chk("err_host", {15'h0, host_en}, 16'(k != 0));
      if (k == 2) begin
        e.addr = 16'h5678;
        pulse_evt(e);
        host.get(SPCS_IDX_SYNX, rd_v);
        chk("synx_first", rd_v, 16'h1234);
      end
    end
    close_out();
  end
  // whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    fail_count++;
    close_out();
  end
endmodule : spcs_regs_test
